// >>> design/fwp_pkg.sv
// package: constants and carrier types of the flash write-protection block
package fwp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // geometry
  localparam int unsigned OTP_BYTES = 1024;
  localparam int unsigned OTP_REGION_BYTES = 32;
  localparam int unsigned OTP_REGIONS = 32;
  localparam int unsigned OTP_RANDOM_BYTES = 16;
  localparam logic [9:0] OTP_LOCK_BASE = 10'h010;
  localparam logic [7:0] OTP_ERASED = 8'hff;
  localparam int unsigned ADDR_W = 26;
  localparam int unsigned SECTOR_W = 8;
  localparam int unsigned SECTORS = 256;
  localparam int unsigned RANGE_HI_W = 6;
  localparam int unsigned ARRAY_KBYTES = 65536;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_WDATA = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_CONFIG = 8'h10;
  localparam logic [7:0] OFF_RDATA = 8'h14;
  localparam logic [7:0] OFF_QUERY = 8'h18;
  localparam logic [7:0] OFF_NONE = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // field positions and reset values
  localparam int unsigned SR_WEL = 1;
  localparam int unsigned SR_BP_LO = 2;
  localparam int unsigned SR_PERR = 6;
  localparam int unsigned SR_STATUS_WRITE_DISABLE_BIT = 7;
  localparam int unsigned CFG_FREEZE = 0;
  localparam int unsigned CFG_TB = 5;
  localparam int unsigned WD_CFG_LO = 8;
  localparam logic [7:0] SR_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // command codes
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_REG_WRITE = 8'h01;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_QUAD_PAGE_PROGRAM = 8'h32;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'hd8;
  localparam logic [7:0] OP_BULK_ERASE = 8'h60;
  localparam logic [7:0] OP_OTP_PROGRAM = 8'h42;
  localparam logic [7:0] OP_OTP_READ = 8'h4b;
  localparam logic [7:0] OP_RESET = 8'hf0;
  localparam logic [7:0] OP_CLEAR_ERR = 8'h30;
  localparam logic [7:0] OP_DYB_WRITE = 8'he1;
  localparam logic [7:0] OP_PPB_PROGRAM = 8'he3;
  localparam logic [7:0] OP_PPB_ERASE = 8'he4;

  localparam logic [1:0] OPK_PROGRAM = 2'h1;
  localparam logic [1:0] OPK_SECTOR_ERASE = 2'h2;
  localparam logic [1:0] OPK_BULK_ERASE = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } fwp_ahb_req_t;

  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } fwp_ahb_rsp_t;

  typedef struct packed {
    logic valid;
    logic [1:0] kind;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } fwp_array_op_t;

  typedef struct packed {
    logic [OTP_BYTES-1:0][7:0] otp;
    logic [SECTORS-1:0] persistent_sector_bit;
    logic [SECTORS-1:0] dynamic_sector_bit;
    logic [7:0] status;
    logic [7:0] cfg;
    logic [ADDR_W-1:0] addr;
    logic [15:0] wdata;
    logic [7:0] rdata;
    logic wr_pend;
    logic [7:0] wr_off;
    logic wp_meta;
    logic wp_sync;
    logic hrst_meta;
    logic hrst_sync;
    fwp_ahb_rsp_t rsp;
    fwp_array_op_t op;
  } fwp_state_t;

endpackage : fwp_pkg

// >>> design/fwp_range_check.sv
// range-protection decode: is an array address inside the protected range
`timescale 1ns/100ps
`default_nettype none
module fwp_range_check (
  input wire logic [fwp_pkg::ADDR_W-1:0] addr,
  input wire logic [2:0] range_bits,
  input wire logic from_bottom,
  output logic hit
);
  import fwp_pkg::*;

  logic [RANGE_HI_W-1:0] hi;
  logic [RANGE_HI_W-1:0] mask;

  assign hi = addr[ADDR_W-1 -: RANGE_HI_W];

  ////////////////////////////////////////////////////////////////////////////
  // range size: 1 -> 64th (six top bits) ... 6 -> half (one top bit)
  assign mask = RANGE_HI_W'(6'h3f << (range_bits - 3'h1));

  // top when clear, bottom when set
  always_comb begin
    if (range_bits == 3'h0) begin
      hit = 1'b0;
    end else if (range_bits == 3'h7) begin
      hit = 1'b1;
    end else if (from_bottom) begin
      hit = ((hi & mask) == 6'h00);
    end else begin
      hit = ((hi & mask) == mask);
    end
  end

endmodule : fwp_range_check
`default_nettype wire

// >>> design/fwp_top.sv
// flash write protection: otp, write-enable latch, block/sector protection
//
// Behaviour
// - 1024-byte otp, 32 lockable 32-byte regions
// - otp read like fast read; outside undefined
// - otp program repeatable, never erased; here hresetn restores the factory image
// - out-of-range otp program ignored, latch stays
// - freeze set: otp program fails, error flag
// - lock byte bits guard one region each
// - lowest lock bit guards lock bytes region
// - latch clears on reset and listed commands
// - range bits select protected size
// - select bit: top when 0, bottom 1
// - block or sector protection protects sector
// - freeze holds range and select bits
// - freeze cleared only by power-on reset
// - freeze clear: range and select writable
// - frozen range write ignored, no error
// - pin low plus disable bit blocks register writes
// - factory random value in bytes 0-15
// - either sector bit zero means protected
//
// Chosen here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module fwp_top #(
  // arbitrary value standing for the factory random number
  parameter logic [127:0] FACTORY_RANDOM = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire fwp_pkg::fwp_ahb_req_t ahb_req,
  output var fwp_pkg::fwp_ahb_rsp_t ahb_rsp,
  input wire logic wp_n,
  input wire logic reset_pin_n,
  output var fwp_pkg::fwp_array_op_t array_op
);
  import fwp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // reset image; otp returns to its factory image, programmed bytes are lost
  // factory random value
  localparam logic [OTP_BYTES-1:0][7:0] OTP_INIT =
    {{(OTP_BYTES - OTP_RANDOM_BYTES){OTP_ERASED}}, FACTORY_RANDOM};
  localparam fwp_ahb_rsp_t RSP_RESET = '{hreadyout: 1'b1, hresp: 1'b0, hrdata: 32'h0};
  localparam fwp_state_t ST_RESET = '{otp: OTP_INIT, persistent_sector_bit: '1, dynamic_sector_bit: '1, status: SR_RESET,
    cfg: CFG_RESET, hrst_meta: 1'b1, hrst_sync: 1'b1, rsp: RSP_RESET,
    // pin synchronisers start at the idle high level, so no false guard after reset
    wp_meta: 1'b1, wp_sync: 1'b1, default: '0};

  fwp_state_t st;
  fwp_state_t next_st;

  // lock bit 0 means programmed, i.e. region locked
  function automatic logic otp_locked(input logic [OTP_BYTES-1:0][7:0] otp,
                                      input logic [9:0] a);
    logic [4:0] region;
    logic [7:0] lock_byte;
    region = a[9:5];
    lock_byte = otp[OTP_LOCK_BASE + {8'h00, region[4:3]}];
    // region 0 lock covers only its upper half
    otp_locked = !lock_byte[region[2:0]] && ((region != 5'h00) || a[4]);
  endfunction : otp_locked

  ////////////////////////////////////////////////////////////////////////////
  // decoded conditions
  logic cmd_go;
  logic [7:0] cmd_op;
  logic write_enable_latch;
  logic frozen;
  logic wp_guard;
  logic otp_in_range;
  logic otp_lock;
  logic [SECTOR_W-1:0] sec;
  logic sec_prot;
  logic range_hit;
  logic array_prot;
  logic any_sec_prot;
  logic [7:0] rd_off;

  assign cmd_go = st.wr_pend && (st.wr_off == OFF_CMD);
  assign cmd_op = ahb_req.hwdata[7:0];
  assign write_enable_latch = st.status[SR_WEL];
  assign frozen = st.cfg[CFG_FREEZE];
  // pin level passes two flops before use
  assign wp_guard = !st.wp_sync && st.status[SR_STATUS_WRITE_DISABLE_BIT];
  assign otp_in_range = (st.addr[ADDR_W-1:10] == 16'h0000);
  assign otp_lock = otp_locked(st.otp, st.addr[9:0]);
  assign sec = st.addr[ADDR_W-1 -: SECTOR_W];
  assign sec_prot = !st.persistent_sector_bit[sec] || !st.dynamic_sector_bit[sec];
  assign any_sec_prot = !(&st.persistent_sector_bit) || !(&st.dynamic_sector_bit);
  assign array_prot = range_hit || sec_prot;
  assign rd_off = (ahb_req.haddr[31:8] == 24'h000000) ? ahb_req.haddr[7:0] : OFF_NONE;

  fwp_range_check u_range (
    .addr(st.addr),
    .range_bits(st.status[SR_BP_LO +: 3]),
    .from_bottom(st.cfg[CFG_TB]),
    .hit(range_hit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_st = st;
    next_st.wp_meta = wp_n;
    next_st.wp_sync = st.wp_meta;
    next_st.hrst_meta = reset_pin_n;
    next_st.hrst_sync = st.hrst_meta;
    next_st.op.valid = 1'b0;
    next_st.rsp.hreadyout = 1'b1;
    next_st.rsp.hresp = 1'b0;
    // data phase of a write: zero wait states, so hwdata is used now
    if (st.wr_pend) begin
      case (st.wr_off)
        OFF_ADDR: begin
          next_st.addr = ahb_req.hwdata[ADDR_W-1:0];
        end
        OFF_WDATA: begin
          next_st.wdata = ahb_req.hwdata[15:0];
        end
        default: begin
        end
      endcase
    end
    if (cmd_go) begin
      case (cmd_op)
        OP_WRITE_ENABLE: begin
          next_st.status[SR_WEL] = 1'b1;
        end
        OP_WRITE_DISABLE: begin
          next_st.status[SR_WEL] = 1'b0;
        end
        // software reset clears latch; volatile sector bits reopen
        OP_RESET: begin
          next_st.status[SR_WEL] = 1'b0;
          next_st.dynamic_sector_bit = '1;
        end
        OP_CLEAR_ERR: begin
          next_st.status[SR_PERR] = 1'b0;
        end
        OP_REG_WRITE: begin
          if (write_enable_latch) begin
            if (!wp_guard) begin
              next_st.status[SR_STATUS_WRITE_DISABLE_BIT] = st.wdata[SR_STATUS_WRITE_DISABLE_BIT];
              // writable while not frozen; silently kept when frozen
              if (!frozen) begin
                next_st.status[SR_BP_LO +: 3] = st.wdata[SR_BP_LO +: 3];
                next_st.cfg[CFG_TB] = st.wdata[WD_CFG_LO + CFG_TB];
              end
              // freeze can only be set by a write
              next_st.cfg[CFG_FREEZE] = frozen || st.wdata[WD_CFG_LO + CFG_FREEZE];
            end
            next_st.status[SR_WEL] = 1'b0;
          end
        end
        OP_PAGE_PROGRAM, OP_QUAD_PAGE_PROGRAM, OP_SECTOR_ERASE: begin
          if (write_enable_latch) begin
            // protected target: nothing reaches the array
            if (array_prot) begin
              next_st.status[SR_PERR] = 1'b1;
            end else begin
              next_st.op.valid = 1'b1;
              next_st.op.kind = (cmd_op == OP_SECTOR_ERASE) ? OPK_SECTOR_ERASE : OPK_PROGRAM;
              next_st.op.addr = st.addr;
              next_st.op.data = st.wdata[7:0];
              next_st.status[SR_WEL] = 1'b0;
            end
          end
        end
        OP_BULK_ERASE: begin
          if (write_enable_latch) begin
            // any protection refuses the whole erase
            if ((st.status[SR_BP_LO +: 3] != 3'h0) || any_sec_prot) begin
              next_st.status[SR_PERR] = 1'b1;
            end else begin
              next_st.op.valid = 1'b1;
              next_st.op.kind = OPK_BULK_ERASE;
              next_st.op.addr = '0;
              next_st.op.data = 8'h00;
              next_st.status[SR_WEL] = 1'b0;
            end
          end
        end
        // outside the otp space: ignored, latch untouched
        OP_OTP_PROGRAM: begin
          if (write_enable_latch && otp_in_range) begin
            // frozen otp fails; locked region refused
            if (frozen || otp_lock) begin
              next_st.status[SR_PERR] = 1'b1;
            end else begin
              // programming only clears bits, so it may repeat
              next_st.otp[st.addr[9:0]] = st.otp[st.addr[9:0]] & st.wdata[7:0];
              next_st.status[SR_WEL] = 1'b0;
            end
          end
        end
        // out-of-range reads wrap; the value is not defined
        OP_OTP_READ: begin
          next_st.rdata = st.otp[st.addr[9:0]];
        end
        OP_DYB_WRITE: begin
          next_st.dynamic_sector_bit[sec] = st.wdata[0];
        end
        OP_PPB_PROGRAM: begin
          next_st.persistent_sector_bit[sec] = 1'b0;
        end
        OP_PPB_ERASE: begin
          next_st.persistent_sector_bit = '1;
        end
        default: begin
        end
      endcase
    end
    // hardware reset pin clears latch and volatile sector bits, winning over any command
    if (!st.hrst_sync) begin
      next_st.status[SR_WEL] = 1'b0;
      next_st.dynamic_sector_bit = '1;
    end
    // address phase; register reads see this cycle's writes, the query read uses the current address
    if (ahb_req.hready) begin
      next_st.wr_pend = 1'b0;
      if (ahb_req.hsel && ahb_req.htrans[1]) begin
        if (ahb_req.hwrite) begin
          next_st.wr_pend = 1'b1;
          next_st.wr_off = rd_off;
        end else begin
          case (rd_off)
            OFF_ADDR: next_st.rsp.hrdata = {6'h00, next_st.addr};
            OFF_WDATA: next_st.rsp.hrdata = {16'h0000, next_st.wdata};
            OFF_STATUS: next_st.rsp.hrdata = {24'h000000, next_st.status};
            OFF_CONFIG: next_st.rsp.hrdata = {24'h000000, next_st.cfg};
            OFF_RDATA: next_st.rsp.hrdata = {24'h000000, next_st.rdata};
            OFF_QUERY: next_st.rsp.hrdata = {30'h00000000, sec_prot, range_hit};
            default: next_st.rsp.hrdata = 32'h00000000;
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; hresetn acts as power-on reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign ahb_rsp = st.rsp;
  assign array_op = st.op;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_freeze_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    st.cfg[CFG_FREEZE] |=> st.cfg[CFG_FREEZE]) else $error("freeze bit cleared");

  a_range_frozen: assert property (@(posedge hclk) disable iff (!hresetn)
    st.cfg[CFG_FREEZE] |=> $stable(st.status[SR_BP_LO +: 3]) && $stable(st.cfg[CFG_TB]))
    else $error("range bits moved while frozen");

  a_frozen_noerr: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_go && cmd_op == OP_REG_WRITE && frozen && !st.status[SR_PERR]
    |=> !st.status[SR_PERR]) else $error("frozen register write raised error");

  a_wel_set: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_go && cmd_op == OP_WRITE_ENABLE && st.hrst_sync |=> st.status[SR_WEL])
    else $error("write enable did not set latch");

  a_wel_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_go && (cmd_op == OP_WRITE_DISABLE || cmd_op == OP_REG_WRITE || cmd_op == OP_RESET)
    |=> !st.status[SR_WEL]) else $error("latch not cleared by command");

  a_otp_range: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_go && cmd_op == OP_OTP_PROGRAM && write_enable_latch && !otp_in_range && st.hrst_sync
    |=> st.status[SR_WEL] && $stable(st.otp)) else $error("out-of-range otp program acted");

  a_otp_frozen: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_go && cmd_op == OP_OTP_PROGRAM && write_enable_latch && otp_in_range && frozen
    |=> st.status[SR_PERR] && $stable(st.otp)) else $error("frozen otp program not failed");

  a_otp_lock: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_go && cmd_op == OP_OTP_PROGRAM && otp_lock |=> $stable(st.otp))
    else $error("locked otp region programmed");

  a_wp_guard: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_go && cmd_op == OP_REG_WRITE && wp_guard
    |=> $stable(st.cfg) && $stable(st.status[SR_STATUS_WRITE_DISABLE_BIT]) && $stable(st.status[SR_BP_LO +: 3]))
    else $error("guarded registers changed");

  a_array_block: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_go && (cmd_op == OP_PAGE_PROGRAM || cmd_op == OP_SECTOR_ERASE) && array_prot
    |=> !array_op.valid) else $error("protected sector reached array");

  a_otp_prog: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_go && cmd_op == OP_OTP_PROGRAM && write_enable_latch && otp_in_range && !frozen && !otp_lock
    |=> st.otp[$past(st.addr[9:0])] == ($past(st.otp[st.addr[9:0]]) & $past(st.wdata[7:0])))
    else $error("otp byte not programmed");

endmodule : fwp_top
`default_nettype wire

// >>> bench/fwp_host_model.sv
// ahb-lite master standing in for the host controller
`timescale 1ns/100ps
`default_nettype none
module fwp_host_model (
  input wire logic hclk,
  input wire fwp_pkg::fwp_ahb_rsp_t ahb_rsp,
  output var fwp_pkg::fwp_ahb_req_t ahb_req
);
  import fwp_pkg::*;
  logic sel = 1'b0;
  logic wr = 1'b0;
  logic [1:0] trans = 2'h0;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  // single whole words only, so hsize never changes
  assign ahb_req = {sel, addr, trans, wr, 3'h2, wdata, ahb_rsp.hreadyout};
  ////////////////////////////////////////////////////////////////////////////
  // no latency assumed: each phase is held until hready is seen high
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    sel <= 1'b1;
    addr <= a;
    trans <= 2'h2;
    wr <= w;
    do @(posedge hclk); while (ahb_rsp.hreadyout !== 1'b1);
    sel <= 1'b0;
    trans <= 2'h0;
    // read data phases carry no write data, so the lines are scrambled
    wdata <= w ? d : ~wdata;
    do @(posedge hclk); while (ahb_rsp.hreadyout !== 1'b1);
    q = ahb_rsp.hrdata;
  endtask : xfer
endmodule : fwp_host_model
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench with a reference model of the protection logic
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import fwp_pkg::*;
  // arbitrary stand-in for the factory random number
  localparam logic [127:0] RND = 128'h5a1c93e704bd6f28c1a07e359d42b8f6;
  localparam logic [7:0] CLR [8] = '{OP_WRITE_DISABLE, OP_REG_WRITE, OP_PAGE_PROGRAM,
    OP_QUAD_PAGE_PROGRAM, OP_SECTOR_ERASE, OP_BULK_ERASE, OP_OTP_PROGRAM, OP_RESET};
  logic hclk;
  logic hresetn;
  logic wp_n;
  logic reset_pin_n;
  fwp_ahb_req_t ahb_req;
  fwp_ahb_rsp_t ahb_rsp;
  fwp_array_op_t array_op;
  int fail_count = 0;
  int total_checks = 0;
  logic [31:0] rnd = 32'h6588b5db;
  logic [31:0] r;
  logic [7:0] otp_m [1024];
  logic [255:0] dyb_m;
  logic [255:0] ppb_m;
  logic write_enable_latch;
  logic perr;
  logic status_write_disable_bit;
  logic frz;
  logic tb;
  logic [2:0] bp;
  logic [25:0] m_addr;
  logic [15:0] m_wd;
  logic [25:0] a;
  logic [26:0] sz;
  logic [27:0] exp_q [$];
  logic [27:0] got_q [$];
  fwp_top #(.FACTORY_RANDOM(RND)) u_fwp_top (.hclk(hclk), .hresetn(hresetn),
    .ahb_req(ahb_req), .ahb_rsp(ahb_rsp), .wp_n(wp_n), .reset_pin_n(reset_pin_n),
    .array_op(array_op));
  fwp_host_model u_fwp_host_model (.hclk(hclk), .ahb_rsp(ahb_rsp), .ahb_req(ahb_req));
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (array_op.valid === 1'b1) begin
      got_q.push_back({array_op.kind, array_op.kind == 2'h3 ? 26'h0 : array_op.addr});
      if (array_op.kind == 2'h1) cmp({24'h0, array_op.data}, {24'h0, m_wd[7:0]});
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [26:0] prot_len();
    if (bp == 3'h0) return 27'h0;
    if (bp == 3'h7) return 27'h4000000;
    return 27'h1 << (19 + bp);
  endfunction : prot_len
  function automatic logic [31:0] query(input logic [25:0] x);
    logic [26:0] s;
    logic h;
    s = prot_len();
    h = (s != 27'h0) && (tb ? ({1'b0, x} < s) : ({1'b0, x} >= 27'h4000000 - s));
    return {30'h0, !dyb_m[x[25:18]] || !ppb_m[x[25:18]], h};
  endfunction : query
  task automatic init_m;
    for (int i = 0; i < 1024; i++) otp_m[i] = (i < 16) ? RND[8*i +: 8] : 8'hff;
    {write_enable_latch, perr, status_write_disable_bit, frz, tb, bp} = 8'h0;
    dyb_m = '1;
    ppb_m = '1;
  endtask : init_m
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : cmp
  task automatic chk(input logic [7:0] o, input logic [31:0] e);
    u_fwp_host_model.xfer(1'b0, {24'h0, o}, 32'h0, r);
    cmp(r, e);
    cmp({31'h0, ahb_rsp.hresp}, 32'h0);
  endtask : chk
  task automatic wr(input logic [7:0] o, input logic [31:0] d);
    u_fwp_host_model.xfer(1'b1, {24'h0, o}, d, r);
  endtask : wr
  task automatic seta(input logic [25:0] x);
    m_addr = x;
    wr(OFF_ADDR, {6'h0, x});
  endtask : seta
  task automatic setd(input logic [15:0] d);
    m_wd = d;
    wr(OFF_WDATA, {16'h0, d});
  endtask : setd
  task automatic chk_regs;
    chk(OFF_STATUS, {24'h0, status_write_disable_bit, perr, 1'b0, bp, write_enable_latch, 1'b0});
    chk(OFF_CONFIG, {26'h0, tb, 4'h0, frz});
    cmp(got_q.size(), exp_q.size());
    foreach (exp_q[i]) if (i < got_q.size()) cmp({4'h0, got_q[i]}, {4'h0, exp_q[i]});
    got_q = {};
    exp_q = {};
  endtask : chk_regs
  task automatic cmd(input logic [7:0] op);
    logic [7:0] s;
    logic [1:0] k;
    logic p;
    s = m_addr[25:18];
    k = (op == OP_SECTOR_ERASE) ? 2'h2 : (op == OP_BULK_ERASE) ? 2'h3 : 2'h1;
    // bulk erase is refused if any range or any sector is protected
    p = (op == OP_BULK_ERASE) ? (bp != 3'h0) || !(&dyb_m) || !(&ppb_m) :
      (query(m_addr) != 32'h0);
    case (op)
      OP_WRITE_ENABLE: write_enable_latch = 1'b1;
      OP_WRITE_DISABLE: write_enable_latch = 1'b0;
      OP_RESET: begin
        write_enable_latch = 1'b0;
        dyb_m = '1;
      end
      OP_CLEAR_ERR: perr = 1'b0;
      OP_DYB_WRITE: dyb_m[s] = m_wd[0];
      OP_PPB_PROGRAM: ppb_m[s] = 1'b0;
      OP_PPB_ERASE: ppb_m = '1;
      OP_REG_WRITE: begin
        if (write_enable_latch && !(status_write_disable_bit && !wp_n)) begin
          status_write_disable_bit = m_wd[7];
          if (!frz) begin
            bp = m_wd[4:2];
            tb = m_wd[13];
          end
          frz = frz | m_wd[8];
        end
        write_enable_latch = 1'b0;
      end
      OP_OTP_PROGRAM: begin
        if (write_enable_latch && m_addr < 26'h400) begin
          if (frz || (!otp_m[16 + m_addr[9:8]][m_addr[7:5]] && (m_addr[9:5] != 5'h0 || m_addr[4]))) begin
            perr = 1'b1;
          end else begin
            otp_m[m_addr[9:0]] &= m_wd[7:0];
            write_enable_latch = 1'b0;
          end
        end
      end
      OP_PAGE_PROGRAM, OP_QUAD_PAGE_PROGRAM, OP_SECTOR_ERASE, OP_BULK_ERASE: begin
        if (write_enable_latch && p) begin
          perr = 1'b1;
        end else if (write_enable_latch) begin
          exp_q.push_back({k, k == 2'h3 ? 26'h0 : m_addr});
          write_enable_latch = 1'b0;
        end
      end
      default: ;
    endcase
    wr(OFF_CMD, {24'h0, op});
  endtask : cmd
  task automatic otp_chk(input logic [25:0] x);
    seta(x);
    cmd(OP_OTP_READ);
    chk(OFF_RDATA, {24'h0, otp_m[x[9:0]]});
  endtask : otp_chk
  task automatic prog_otp(input logic [25:0] x, input logic [7:0] d);
    seta(x);
    setd({8'h0, d});
    cmd(OP_WRITE_ENABLE);
    cmd(OP_OTP_PROGRAM);
    chk_regs;
    otp_chk(x);
  endtask : prog_otp
  task automatic regw(input logic [7:0] s, input logic [7:0] c);
    setd({c, s});
    cmd(OP_WRITE_ENABLE);
    cmd(OP_REG_WRITE);
    chk_regs;
  endtask : regw
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    close_out;
  end
  initial begin
    hresetn = 1'b0;
    wp_n = 1'b1;
    reset_pin_n = 1'b1;
    init_m;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk_regs;
    for (int i = 0; i < 18; i++) otp_chk(i[25:0]);
    chk(OFF_CMD, 32'h0);
    u_fwp_host_model.xfer(1'b0, 32'h100, 32'h0, r);
    cmp(r, 32'h0);
    seta(26'h3f0);
    setd(16'h0);
    foreach (CLR[i]) begin
      cmd(OP_WRITE_ENABLE);
      chk_regs;
      cmd(CLR[i]);
      chk_regs;
    end
    otp_chk(26'h3f0);
    seta(26'h400);
    cmd(OP_WRITE_ENABLE);
    cmd(OP_OTP_PROGRAM);
    chk_regs;
    cmd(OP_WRITE_DISABLE);
    rnd = lfsr(rnd);
    // bit 6 set keeps both test regions clear of the lock bytes
    a = {16'h0, rnd[9:0]} | 26'h40;
    prog_otp(a, rnd[23:16]);
    prog_otp(a, rnd[31:24]);
    prog_otp(a ^ 26'h20, 8'h5a);
    prog_otp(26'h10 | {24'h0, a[9:8]}, ~(8'h1 << a[7:5]));
    prog_otp(a, 8'h0);
    prog_otp(a ^ 26'h20, 8'h0f);
    prog_otp(26'h10, 8'hfe);
    prog_otp(26'h14, 8'h0);
    prog_otp(26'h04, 8'h0f);
    cmd(OP_CLEAR_ERR);
    cmd(OP_WRITE_DISABLE);
    chk_regs;
    for (int k = 0; k < 16; k++) begin
      regw({3'h0, k[2:0], 2'h0}, {2'h0, k[3], 5'h0});
      rnd = lfsr(rnd);
      sz = tb ? prot_len() : 27'h4000000 - prot_len();
      for (int j = 0; j < 3; j++) begin
        a = (j == 0) ? sz[25:0] - 26'h1 : (j == 1) ? sz[25:0] : rnd[25:0];
        seta(a);
        chk(OFF_QUERY, query(a));
      end
      seta(sz[25:0]);
      cmd(OP_WRITE_ENABLE);
      cmd(OP_PAGE_PROGRAM);
      chk_regs;
      cmd(OP_CLEAR_ERR);
      cmd(OP_WRITE_DISABLE);
    end
    // sector bits used alone, range protection off
    regw(8'h0, 8'h0);
    rnd = lfsr(rnd);
    seta(rnd[25:0]);
    setd(16'h0);
    cmd(OP_DYB_WRITE);
    chk(OFF_QUERY, query(m_addr));
    cmd(OP_WRITE_ENABLE);
    cmd(OP_SECTOR_ERASE);
    chk_regs;
    setd(16'h1);
    cmd(OP_DYB_WRITE);
    cmd(OP_PPB_PROGRAM);
    chk(OFF_QUERY, query(m_addr));
    cmd(OP_SECTOR_ERASE);
    chk_regs;
    cmd(OP_PPB_ERASE);
    cmd(OP_SECTOR_ERASE);
    chk_regs;
    cmd(OP_CLEAR_ERR);
    regw(8'h08, 8'h20);
    regw(8'h08, 8'h21);
    regw(8'h14, 8'h00);
    prog_otp(26'h300, 8'h0);
    cmd(OP_CLEAR_ERR);
    cmd(OP_RESET);
    chk(OFF_CONFIG, 32'h21);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    init_m;
    @(posedge hclk);
    chk_regs;
    regw(8'h80, 8'h00);
    wp_n <= 1'b0;
    repeat (3) @(posedge hclk);
    regw(8'h0c, 8'h20);
    wp_n <= 1'b1;
    repeat (3) @(posedge hclk);
    regw(8'h0c, 8'h20);
    cmd(OP_WRITE_ENABLE);
    reset_pin_n <= 1'b0;
    repeat (4) @(posedge hclk);
    reset_pin_n <= 1'b1;
    repeat (3) @(posedge hclk);
    write_enable_latch = 1'b0;
    dyb_m = '1;
    chk_regs;
    close_out;
  end
endmodule : testbench
`default_nettype wire
